// ### src/oscillator_source_config.sv
// Purpose: Start-up clock source selection, clock enables and clock-out pin
// Assumes: Non-volatile words are stable while rst_n is low and after
// Notes:   Slower clocks are enables of core_clk, except instr_clk, which is a level toggled on sys_clock_en
//
// Notes on behaviour
// - Instruction clock is the selected system clock divided by two.
// - Source loads from initial field just after reset release; later changes only via switching or fail-safe fallback to RC.
// - Source codes: 000 RC, 001 RC+PLL, 010 primary, 011 primary+PLL; rest reserved.
// - Primary mode: 11 off, 10 crystal, 00 external clock, 01 reserved.
// - Primary mode field ignored while an internal RC source is selected.
// - Outside crystal mode, clock-out bit 1 drives instruction clock, 0 gives GPIO.
// - Switch/monitor: 1x none, 01 switching only, 00 switching and fail-safe.
// - Range bit 1 selects high RC/PLL range, 0 the low range.
// - With PLL: PWM clock is PLL output, converter clock is PLL divided by 2.
// - With PLL: system clock is PLL divided by eight, then two for instruction.
// - Reset loads 000 RC; two cycles after release the current source status takes the initial source field, or 000 RC for a reserved code.
module oscillator_source_config
  import osc_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [23:0] nv_source_word,
  input  wire logic [23:0] nv_mode_word,
  input  wire logic        clock_fail_detect,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  input  wire logic        osc_pin_out_in,
  output logic             osc_pin_out_o,
  output logic             osc_pin_out_oe,
  output logic             gpio_in,
  output logic             instr_clk,
  output logic             sys_clock_en,
  output logic             pwm_clock_en,
  output logic             converter_clock_en,
  output logic [2:0]       current_source_status,
  output logic             primary_osc_enable,
  output logic             high_speed_crystal_mode,
  output logic             rc_high_range,
  output logic             fail_safe_monitor_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ==========================================================================
  // Declarations
  osc_cfg_t          cfg;
  logic              cfg_loaded;
  source_t           cur_src;
  logic              fail_flag;
  logic [2:0]        new_src;
  logic              switch_req;
  logic [2:0]        div8_cnt;
  logic              conv_phase;
  logic              sys_en;
  logic              next_instr_clk;
  logic              pll_in_use;
  logic              crystal_sel;
  logic              switch_allowed;
  logic              monitor_on;
  logic              fail_meta;
  logic              fail_sync;
  logic              gpio_meta;
  logic              access_ok;
  logic              bus_take;
  logic [31:0]       next_readdata;
  clk_en_t           next_en;

  // ==========================================================================
  // Configuration capture after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg        <= '0;
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg.initial_source_sel   <= nv_source_word[SRC_LSB +: 3];
      cfg.primary_osc_mode     <= nv_mode_word[MODE_LSB +: 2];
      cfg.clock_out_pin_enable <= nv_mode_word[CLKOUT_BIT];
      cfg.rc_speed_range       <= nv_mode_word[RANGE_BIT];
      cfg.switch_monitor_sel   <= nv_mode_word[SWMON_LSB +: 2];
      cfg_loaded               <= 1'b1;
    end
  end

  // ==========================================================================
  // Decoded configuration
  always_comb begin
    pll_in_use     = (cur_src == SRC_RC_PLL) || (cur_src == SRC_PRI_PLL);
    // Mode field only counts for primary sources
    crystal_sel    = ((cur_src == SRC_PRI) || (cur_src == SRC_PRI_PLL)) &&
                     (cfg.primary_osc_mode == MODE_CRYSTAL);
    switch_allowed = cfg_loaded && !cfg.switch_monitor_sel[1];
    monitor_on     = cfg_loaded && (cfg.switch_monitor_sel == SWMON_BOTH);
  end

  // ==========================================================================
  // Fail detect synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_meta <= 1'b0;
      fail_sync <= 1'b0;
    end else begin
      fail_meta <= clock_fail_detect;
      fail_sync <= fail_meta;
    end
  end

  // ==========================================================================
  // Current source selection
  function automatic source_t to_source(input logic [2:0] code);
    source_t s;
    s = SRC_RC;
    unique case (code)
      3'h0:    s = SRC_RC;
      3'h1:    s = SRC_RC_PLL;
      3'h2:    s = SRC_PRI;
      3'h3:    s = SRC_PRI_PLL;
      default: s = SRC_RC;
    endcase
    return s;
  endfunction : to_source

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_src <= SRC_RC;
    end else if (!cfg_loaded) begin
      cur_src <= to_source(nv_source_word[SRC_LSB +: 3]);
    end else if (monitor_on && fail_sync) begin
      cur_src <= SRC_RC;
    end else if (switch_req && switch_allowed && !new_src[2]) begin
      cur_src <= to_source(new_src);
    end
  end

  // Sticky fail flag; a new failure wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_flag <= 1'b0;
    end else if (monitor_on && fail_sync) begin
      fail_flag <= 1'b1;
    end else if (bus_take && avs_write && avs_address == OFS_STATUS &&
                 avs_byteenable[0] && avs_writedata[STAT_FAIL_BIT]) begin
      fail_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Switch request register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      new_src    <= 3'h0;
      switch_req <= 1'b0;
    end else if (bus_take && avs_write && avs_address == OFS_SWITCH &&
                 avs_byteenable[0]) begin
      new_src    <= avs_writedata[SRC_LSB +: 3];
      switch_req <= avs_writedata[SW_REQ_BIT];
    end else begin
      switch_req <= 1'b0;
    end
  end

  // ==========================================================================
  // Clock dividers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div8_cnt   <= 3'h0;
      conv_phase <= 1'b0;
    end else begin
      div8_cnt   <= pll_in_use ? div8_cnt + 3'h1 : 3'h0;
      conv_phase <= pll_in_use ? !conv_phase : 1'b0;
    end
  end

  always_comb begin
    // PLL output divided by eight, otherwise the source itself
    sys_en                     = pll_in_use ? (div8_cnt == PLL_SYS_DIV_LAST) : 1'b1;
    next_en.sys_clock_en       = cfg_loaded && sys_en;
    next_en.pwm_clock_en       = cfg_loaded && pll_in_use;
    next_en.converter_clock_en = cfg_loaded && pll_in_use && conv_phase;
    next_instr_clk             = next_en.sys_clock_en ? !instr_clk : instr_clk;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clock_en       <= 1'b0;
      pwm_clock_en       <= 1'b0;
      converter_clock_en <= 1'b0;
      instr_clk          <= 1'b0;
    end else begin
      sys_clock_en       <= next_en.sys_clock_en;
      pwm_clock_en       <= next_en.pwm_clock_en;
      converter_clock_en <= next_en.converter_clock_en;
      instr_clk          <= next_instr_clk;
    end
  end

  // ==========================================================================
  // Second oscillator pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_pin_out_o  <= 1'b0;
      osc_pin_out_oe <= 1'b0;
    end else if (!cfg_loaded || crystal_sel) begin
      osc_pin_out_o  <= 1'b0;
      osc_pin_out_oe <= 1'b0;
    end else if (cfg.clock_out_pin_enable) begin
      osc_pin_out_o  <= next_instr_clk;
      osc_pin_out_oe <= 1'b1;
    end else begin
      osc_pin_out_o  <= gpio_out;
      osc_pin_out_oe <= gpio_oe;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_meta <= 1'b0;
      gpio_in   <= 1'b0;
    end else begin
      gpio_meta <= osc_pin_out_in;
      gpio_in   <= gpio_meta;
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_source_status   <= 3'h0;
      primary_osc_enable      <= 1'b0;
      high_speed_crystal_mode <= 1'b0;
      rc_high_range           <= 1'b0;
      fail_safe_monitor_en    <= 1'b0;
    end else begin
      current_source_status   <= cur_src;
      primary_osc_enable      <= !cur_src[1] ? 1'b0 :
                                 (cfg.primary_osc_mode != MODE_OFF);
      high_speed_crystal_mode <= crystal_sel;
      rc_high_range           <= cfg.rc_speed_range;
      fail_safe_monitor_en    <= monitor_on;
    end
  end

  // ==========================================================================
  // Avalon-MM slave, one wait state on every access
  assign access_ok = (avs_read || avs_write) && (avs_address[1:0] == 2'h0);
  assign bus_take  = (avs_read || avs_write) && !avs_waitrequest;

  always_comb begin
    next_readdata = 32'h0;
    if (access_ok) begin
      unique case (avs_address)
        OFS_INIT_SRC: next_readdata = {8'h00, nv_source_word & SRC_WORD_MASK};
        OFS_MODE_CFG: next_readdata = {8'h00, nv_mode_word & MODE_WORD_MASK};
        OFS_STATUS: begin
          next_readdata[SRC_LSB +: 3]   = cur_src;
          next_readdata[STAT_PLL_BIT]   = pll_in_use;
          next_readdata[STAT_SWEN_BIT]  = switch_allowed;
          next_readdata[STAT_MON_BIT]   = monitor_on;
          next_readdata[STAT_FAIL_BIT]  = fail_flag;
        end
        OFS_SWITCH:   next_readdata[SRC_LSB +: 3] = new_src;
        default:      next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_readdata <= avs_read ? next_readdata : 32'h0;
      end
    end
  end

endmodule : oscillator_source_config

// ### src/osc_cfg_pkg.sv
// Purpose: Shared constants and types for the oscillator source configuration block
// Assumes: 100 MHz core_clk stands for the selected source or PLL output
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
package osc_cfg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0]  OFS_INIT_SRC    = 4'h0;
  localparam logic [3:0]  OFS_MODE_CFG    = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h8;
  localparam logic [3:0]  OFS_SWITCH      = 4'hC;

  // ==========================================================================
  // Field positions
  localparam int          SRC_LSB         = 0;
  localparam int          MODE_LSB        = 0;
  localparam int          CLKOUT_BIT      = 2;
  localparam int          RANGE_BIT       = 5;
  localparam int          SWMON_LSB       = 6;
  localparam int          STAT_PLL_BIT    = 4;
  localparam int          STAT_SWEN_BIT   = 5;
  localparam int          STAT_MON_BIT    = 6;
  localparam int          STAT_FAIL_BIT   = 7;
  localparam int          SW_REQ_BIT      = 4;
  localparam logic [23:0] SRC_WORD_MASK   = 24'h000007;
  localparam logic [23:0] MODE_WORD_MASK  = 24'h0000E7;

  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    SRC_RC      = 3'h0,
    SRC_RC_PLL  = 3'h1,
    SRC_PRI     = 3'h2,
    SRC_PRI_PLL = 3'h3
  } source_t;

  localparam logic [1:0]  MODE_EXT_CLOCK  = 2'h0;
  localparam logic [1:0]  MODE_CRYSTAL    = 2'h2;
  localparam logic [1:0]  MODE_OFF        = 2'h3;
  localparam logic [1:0]  SWMON_BOTH      = 2'h0;
  localparam logic [1:0]  SWMON_SW_ONLY   = 2'h1;

  // ==========================================================================
  // Divider counts
  localparam logic [2:0]  PLL_SYS_DIV_LAST = 3'h7;

  typedef struct packed {
    logic [1:0] switch_monitor_sel;
    logic       rc_speed_range;
    logic       clock_out_pin_enable;
    logic [1:0] primary_osc_mode;
    logic [2:0] initial_source_sel;
  } osc_cfg_t;

  typedef struct packed {
    logic pwm_clock_en;
    logic converter_clock_en;
    logic sys_clock_en;
  } clk_en_t;

endpackage : osc_cfg_pkg

// ### dv/osc_cfg_props.sv
// Purpose: Port assertions for the oscillator source configuration block
// Assumes: Config words change only while rst_n is low
// Notes:   Bound from the bench top file
module osc_cfg_props
  import osc_cfg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [23:0] nv_source_word,
  input wire logic [23:0] nv_mode_word,
  input wire logic        gpio_out,
  input wire logic        gpio_oe,
  input wire logic        osc_pin_out_o,
  input wire logic        osc_pin_out_oe,
  input wire logic        instr_clk,
  input wire logic        sys_clock_en,
  input wire logic        pwm_clock_en,
  input wire logic        converter_clock_en,
  input wire logic [2:0]  current_source_status,
  input wire logic        high_speed_crystal_mode,
  input wire logic        rc_high_range,
  input wire logic        fail_safe_monitor_en,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        clock_fail_detect,
  input wire logic        osc_pin_out_in,
  input wire logic        gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Helpers
  logic [2:0] up;
  logic [3:0] gap;
  logic       rdy;
  logic       sw_hit;
  assign rdy = up == 3'h4;
  assign sw_hit = avs_write && !avs_waitrequest && avs_address == OFS_SWITCH
                  && avs_writedata[SW_REQ_BIT];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) up <= 3'h0;
    else if (!rdy) up <= up + 3'h1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) gap <= 4'h0;
    else if (sys_clock_en) gap <= 4'h0;
    else if (gap != 4'hF) gap <= gap + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence no_pll;
    rdy && !pwm_clock_en && !$past(pwm_clock_en) && !$past(pwm_clock_en, 2);
  endsequence
  sequence pin_free;
    rdy && !high_speed_crystal_mode && !$past(high_speed_crystal_mode)
      && !$past(high_speed_crystal_mode, 2);
  endsequence
  sequence toggled;
    instr_clk != $past(instr_clk);
  endsequence
  // ==========
  // Assertions
  rst_src_a: assert property (
    $rose(rst_n) |-> ##2 current_source_status == (nv_source_word[2] ? 3'h0 : nv_source_word[2:0]))
    else $error("Current source not loaded at reset");
  nopll_div_a: assert property (no_pll |-> sys_clock_en ##0 toggled)
    else $error("Instruction clock not half of system clock");
  pll_div_a: assert property (
    sys_clock_en && pwm_clock_en && $past(pwm_clock_en, 16) |-> gap == 4'h7)
    else $error("System enable spacing wrong with PLL");
  conv_div_a: assert property (
    pwm_clock_en && $past(pwm_clock_en, 2) |-> converter_clock_en != $past(converter_clock_en))
    else $error("Converter enable not every second cycle");
  clkout_a: assert property (
    pin_free ##0 nv_mode_word[CLKOUT_BIT] |-> osc_pin_out_oe && osc_pin_out_o == instr_clk)
    else $error("Clock out not on pin");
  gpio_a: assert property (
    pin_free ##0 !nv_mode_word[CLKOUT_BIT] |-> osc_pin_out_oe == $past(gpio_oe)
      && (!osc_pin_out_oe || osc_pin_out_o == $past(gpio_out)))
    else $error("Pin not general purpose");
  crystal_a: assert property (
    rdy && high_speed_crystal_mode && $past(high_speed_crystal_mode) |-> !osc_pin_out_oe)
    else $error("Pin driven in crystal mode");
  monitor_a: assert property (
    rdy |-> fail_safe_monitor_en == (nv_mode_word[SWMON_LSB +: 2] == SWMON_BOTH))
    else $error("Monitor enable wrong");
  range_a: assert property (rdy |-> rc_high_range == nv_mode_word[RANGE_BIT])
    else $error("Range output wrong");
  switch_a: assert property (
    rdy && $changed(current_source_status) |-> $past(sw_hit, 2) || $past(sw_hit, 3)
      || (fail_safe_monitor_en && $past(clock_fail_detect, 4)))
    else $error("Source changed without switch");
  fail_src_a: assert property (
    rdy && fail_safe_monitor_en && $past(clock_fail_detect, 4) |-> current_source_status == 3'h0)
    else $error("Source not internal RC after failure");
  gpio_sync_a: assert property (rdy |-> gpio_in == $past(osc_pin_out_in, 2))
    else $error("Pin input not passed to general purpose input");
  lock_a: assert property (
    rdy && nv_mode_word[SWMON_LSB + 1] |-> $stable(current_source_status))
    else $error("Source changed while switching disabled");
endmodule : osc_cfg_props

// ### dv/osc_far_side.sv
// Purpose: Far side model: programmer of the config words and the pad
// Assumes: Fields held steady while reset is low
// Notes:   Undriven pad shows the inverse of its last level
module osc_far_side
  import osc_cfg_pkg::*;
(
  input  wire logic     core_clk,
  input  wire osc_cfg_t cfg,
  input  wire logic     dev_o,
  input  wire logic     dev_oe,
  input  wire logic     ext_o,
  input  wire logic     ext_oe,
  output logic [23:0]   nv_source_word,
  output logic [23:0]   nv_mode_word,
  output logic          pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'h0;
  // ==========
  // Programmed words, unused bits at one
  assign nv_source_word = {21'h1FFFFF, cfg.initial_source_sel};
  assign nv_mode_word   = {16'hFFFF, cfg.switch_monitor_sel, cfg.rc_speed_range, 2'h3,
                           cfg.clock_out_pin_enable, cfg.primary_osc_mode};
  // ==========
  // Pad level
  always @(posedge core_clk) last <= pad;
  assign pad = dev_oe ? dev_o : (ext_oe ? ext_o : !last);
endmodule : osc_far_side

// ### dv/test_oscillator_source_config.sv
// Purpose: Self-checking bench for the oscillator source configuration block
// Assumes: Config fields change only while reset is low
// Notes:   Fixed seed; each iteration resets with a new configuration
module test_oscillator_source_config
  import osc_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, gpio_out, gpio_oe, ext_o, ext_oe, osc_pin_out_in;
  logic        osc_pin_out_o, osc_pin_out_oe, gpio_in, instr_clk, sys_clock_en;
  logic        pwm_clock_en, converter_clock_en, primary_osc_enable, avs_waitrequest;
  logic        high_speed_crystal_mode, rc_high_range, fail_safe_monitor_en;
  logic        avs_read, avs_write;
  logic        fail_in;
  logic [2:0]  current_source_status;
  logic [3:0]  avs_address;
  logic [23:0] nv_source_word, nv_mode_word;
  logic [31:0] avs_writedata, avs_readdata, rd;
  osc_cfg_t    cfg;
  int          err_total, samples_checked;

  oscillator_source_config i_oscillator_source_config (
    .core_clk, .rst_n, .nv_source_word, .nv_mode_word, .clock_fail_detect(fail_in), .gpio_out,
    .gpio_oe, .osc_pin_out_in, .osc_pin_out_o, .osc_pin_out_oe, .gpio_in, .instr_clk,
    .sys_clock_en, .pwm_clock_en, .converter_clock_en, .current_source_status,
    .primary_osc_enable, .high_speed_crystal_mode, .rc_high_range, .fail_safe_monitor_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest);
  osc_far_side i_osc_far_side (.core_clk, .cfg, .dev_o(osc_pin_out_o),
    .dev_oe(osc_pin_out_oe), .ext_o, .ext_oe, .nv_source_word, .nv_mode_word,
    .pad(osc_pin_out_in));

  // ==========
  // Clock, pin traffic, helpers
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    {gpio_out, gpio_oe, ext_o, ext_oe} <= 4'($urandom);
  end
  function automatic logic [2:0] eff_src(input logic [2:0] c);
    return c[2] ? 3'h0 : c;
  endfunction : eff_src
  function automatic logic has_pll(input logic [2:0] c);
    return c == SRC_RC_PLL || c == SRC_PRI_PLL;
  endfunction : has_pll
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge core_clk);
  endtask : bus
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ==========
  // Main sequence
  initial begin
    logic [2:0] code, cur;
    logic       pll, prev;
    int         n_sys, n_tog, n_conv;
    void'($urandom(63586));
    {err_total, samples_checked} = '0;
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, cfg, fail_in} = '0;
    for (int i = 0; i < 16; i++) begin
      rst_n <= 1'h0;
      cfg <= {4'($urandom), 2'(i[3:2] ^ i[1:0]), 3'(i)};
      repeat (20) @(posedge core_clk);
      chk(instr_clk, 1'h0);
      rst_n <= 1'h1;
      repeat (4) @(posedge core_clk);
      code = cfg.initial_source_sel;
      cur = eff_src(code);
      pll = has_pll(cur);
      chk(current_source_status, cur);
      chk(primary_osc_enable, cur[1] && cfg.primary_osc_mode != MODE_OFF);
      chk(high_speed_crystal_mode, cur[1] && cfg.primary_osc_mode == MODE_CRYSTAL);
      chk(rc_high_range, cfg.rc_speed_range);
      chk(fail_safe_monitor_en, cfg.switch_monitor_sel == SWMON_BOTH);
      chk(pwm_clock_en, pll);
      {n_sys, n_tog, n_conv} = '0;
      prev = instr_clk;
      repeat (16) begin
        @(posedge core_clk);
        n_sys += int'(sys_clock_en === 1'h1);
        n_tog += int'(instr_clk !== prev);
        n_conv += int'(converter_clock_en === 1'h1);
        prev = instr_clk;
      end
      chk(n_sys, pll ? 2 : 16);
      chk(n_tog, pll ? 2 : 16);
      chk(n_conv, pll ? 8 : 0);
      bus(1'h0, OFS_INIT_SRC, 32'h0);
      chk(rd, {29'h0, code});
      bus(1'h0, OFS_MODE_CFG, 32'h0);
      chk(rd, {24'h0, cfg[8:6], 2'h0, cfg[5:3]});
      bus(1'h0, 4'h5, 32'h0);
      chk(rd, 32'h0);
      code = 3'($urandom);
      bus(1'h1, OFS_SWITCH, {27'h0, 1'h1, 1'h0, code});
      if (!cfg.switch_monitor_sel[1] && !code[2]) cur = code;
      repeat (3) @(posedge core_clk);
      chk(current_source_status, cur);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rd[7:0], {1'h0, cfg.switch_monitor_sel == SWMON_BOTH,
                   !cfg.switch_monitor_sel[1], has_pll(cur), 1'h0, cur});
      // ==========
      // Clock failure, fail flag and its clear
      fail_in <= 1'h1;
      repeat (6) @(posedge core_clk);
      fail_in <= 1'h0;
      if (cfg.switch_monitor_sel == SWMON_BOTH) cur = 3'h0;
      repeat (2) @(posedge core_clk);
      chk(current_source_status, cur);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rd[7], cfg.switch_monitor_sel == SWMON_BOTH);
      bus(1'h1, OFS_STATUS, 32'h80);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rd[7], 1'h0);
    end
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : test_oscillator_source_config

bind oscillator_source_config osc_cfg_props i_osc_cfg_props (.core_clk, .rst_n,
  .nv_source_word, .nv_mode_word, .gpio_out, .gpio_oe, .osc_pin_out_o, .osc_pin_out_oe,
  .instr_clk, .sys_clock_en, .pwm_clock_en, .converter_clock_en, .current_source_status,
  .high_speed_crystal_mode, .rc_high_range, .fail_safe_monitor_en, .avs_address, .avs_write,
  .avs_writedata, .avs_waitrequest, .clock_fail_detect, .osc_pin_out_in, .gpio_in);
